/* hw/summary_lane.sv */
// Purpose: one status byte lane: gates a summary bit with its enable
//          bit and flags the cycle in which the gated product rises.
// Assumes: src and en are synchronous to ref_clk.
// Notes:   the product is combinational; only its previous value is held.
`timescale 1ns/10ps
`default_nettype none

module summary_lane (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic src,
   input  wire logic en,
   output logic      prod,
   output logic      rise
);

   typedef struct packed {
      logic prod_prev;
   } lane_state_t;

   lane_state_t state_q;
   lane_state_t state_d;

   always_comb begin
      prod              = src & en;
      rise              = prod & ~state_q.prod_prev;
      state_d           = state_q;
      state_d.prod_prev = prod;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

endmodule

`default_nettype wire

/* hw/service_request_status_byte.sv */
// Purpose: status byte, request enable mask and service request logic.
// Assumes: all command strobes are one-cycle pulses on ref_clk (200 MHz).
// Notes:   rst stands for power-up; it is the only thing that clears the
//          enable mask apart from a write.
package srq_pkg;
   localparam int         BYTE_W         = 8;
   localparam int         BIT_MEAS       = 0;
   localparam int         BIT_UNUSED     = 1;
   localparam int         BIT_ERR_QUEUE  = 2;
   localparam int         BIT_QUEST      = 3;
   localparam int         BIT_MSG_READY  = 4;
   localparam int         BIT_STD_EVENT  = 5;
   localparam int         BIT_REQUEST    = 6;
   localparam int         BIT_OPER       = 7;
   localparam logic [7:0] BYTE_ZERO      = 8'h00;
   localparam logic [7:0] MASK_RESET     = 8'h00;
   localparam logic [7:0] REQ_CAPABLE    = 8'hbd;
   localparam logic [7:0] REQ_BIT_MASK   = 8'h40;
   localparam logic [7:0] ONLY_ERR_QUEUE = 8'h04;
endpackage

`timescale 1ns/10ps
`default_nettype none

module service_request_status_byte
   import srq_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              measurement_summary,
   input  wire logic              error_queue_nonempty,
   input  wire logic              questionable_summary,
   input  wire logic              output_message_ready,
   input  wire logic              standard_event_summary,
   input  wire logic              operation_summary,
   input  wire logic              mask_wr,
   input  wire logic [BYTE_W-1:0] mask_wdata,
   input  wire logic              mask_rd,
   input  wire logic              stb_query,
   input  wire logic              serial_poll,
   input  wire logic              clear_status,
   input  wire logic              status_preset,
   output logic [BYTE_W-1:0]      status_summary_byte,
   output logic [BYTE_W-1:0]      request_enable_mask,
   output logic                   service_request,
   output logic                   request_service_flag,
   output logic                   resp_valid,
   output logic [BYTE_W-1:0]      resp_data,
   output logic                   poll_valid,
   output logic [BYTE_W-1:0]      poll_byte
);

   typedef struct packed {
      logic [BYTE_W-1:0] status_byte;
      logic [BYTE_W-1:0] mask;
      logic              req_flag;
      logic              srq;
      logic              resp_valid;
      logic [BYTE_W-1:0] resp_data;
      logic              poll_valid;
      logic [BYTE_W-1:0] poll_byte;
   } srq_state_t;

   srq_state_t        state_q;
   srq_state_t        state_d;
   logic [BYTE_W-1:0] summary;
   logic [BYTE_W-1:0] prod;
   logic [BYTE_W-1:0] rise;
   logic              master_summary;
   logic              any_rise;
   logic [BYTE_W-1:0] live_byte;
   logic [BYTE_W-1:0] flag_byte;

   // non-latching summary vector; bits 1 and 6 carry no source
   always_comb begin
      summary             = BYTE_ZERO;
      summary[BIT_MEAS]   = measurement_summary;
      summary[BIT_ERR_QUEUE] = error_queue_nonempty;
      summary[BIT_QUEST]     = questionable_summary;
      summary[BIT_MSG_READY] = output_message_ready;
      summary[BIT_STD_EVENT] = standard_event_summary;
      summary[BIT_OPER]      = operation_summary;
   end

   // the lane edge works on the gated product, so enabling a mask bit
   // while its summary is already high also counts as a rising bit
   for (genvar i = 0; i < BYTE_W; i++) begin : g_lane
      summary_lane u_lane (
         .ref_clk (ref_clk),
         .rst     (rst),
         .src     (summary[i]),
         .en      (state_q.mask[i] & REQ_CAPABLE[i]),
         .prod    (prod[i]),
         .rise    (rise[i])
      );
   end

   always_comb begin
      master_summary     = |prod;
      any_rise           = |rise;
      live_byte          = summary;
      live_byte[BIT_REQUEST] = master_summary;
      flag_byte              = summary;
      flag_byte[BIT_REQUEST] = state_q.req_flag;
   end

   always_comb begin
      state_d             = state_q;
      state_d.status_byte = live_byte;
      state_d.resp_valid  = 1'b0;
      state_d.poll_valid  = 1'b0;
      // clear_status and status_preset are not looked at here on purpose
      if (mask_wr) begin
         state_d.mask = mask_wdata;
      end
      // a rise in the poll cycle must not be lost, so set beats clear
      if (any_rise) begin
         state_d.req_flag = 1'b1;
      end else if (serial_poll) begin
         state_d.req_flag = 1'b0;
      end
      state_d.srq = state_d.req_flag;
      if (serial_poll) begin
         state_d.poll_valid = 1'b1;
         state_d.poll_byte  = flag_byte;
      end
      // a byte query wins over a mask query in the same cycle
      if (stb_query) begin
         state_d.resp_valid = 1'b1;
         state_d.resp_data  = live_byte;
      end else if (mask_rd) begin
         state_d.resp_valid = 1'b1;
         state_d.resp_data  = state_q.mask;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q             <= '0;
         state_q.mask        <= MASK_RESET;
         state_q.status_byte <= BYTE_ZERO;
      end else begin
         state_q <= state_d;
      end
   end

   assign status_summary_byte  = state_q.status_byte;
   assign request_enable_mask  = state_q.mask;
   assign service_request      = state_q.srq;
   assign request_service_flag = state_q.req_flag;
   assign resp_valid           = state_q.resp_valid;
   assign resp_data            = state_q.resp_data;
   assign poll_valid           = state_q.poll_valid;
   assign poll_byte            = state_q.poll_byte;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // the byte lags its sources by one cycle, so most checks look one edge on
   a_byte_follows: assert property (
      ##1 (status_summary_byte & ~REQ_BIT_MASK)
          == ($past(summary) & ~REQ_BIT_MASK))
      else $error("summary bits do not follow their sources");

   a_meas_bit: assert property (
      measurement_summary |=> status_summary_byte[BIT_MEAS])
      else $error("measurement summary bit missing");

   a_err_queue_bit: assert property (
      !error_queue_nonempty |=> !status_summary_byte[BIT_ERR_QUEUE])
      else $error("error bit set with empty error queue");

   a_quest_bit: assert property (
      questionable_summary |=> status_summary_byte[BIT_QUEST])
      else $error("questionable summary bit missing");

   a_msg_ready_bit: assert property (
      output_message_ready |=> status_summary_byte[BIT_MSG_READY])
      else $error("message ready bit missing");

   a_std_event_bit: assert property (
      standard_event_summary ##1 !standard_event_summary
      |=> !status_summary_byte[BIT_STD_EVENT])
      else $error("standard summary bit held after source dropped");

   a_oper_bit: assert property (
      operation_summary |=> status_summary_byte[BIT_OPER])
      else $error("operation summary bit missing");

   a_master_or: assert property (
      ##1 status_summary_byte[BIT_REQUEST]
          == |($past(summary) & $past(request_enable_mask) & REQ_CAPABLE))
      else $error("master summary is not the gated OR");

   a_master_drops: assert property (
      !master_summary |=> !status_summary_byte[BIT_REQUEST])
      else $error("master summary held with no enabled bit");

   a_poll_flag: assert property (
      serial_poll |=> poll_valid
                      && poll_byte[BIT_REQUEST] == $past(request_service_flag))
      else $error("poll byte bit 6 is not the request flag");

   a_poll_bits: assert property (
      serial_poll |=> (poll_byte & ~REQ_BIT_MASK)
                      == ($past(summary) & ~REQ_BIT_MASK))
      else $error("poll byte summary bits wrong");

   a_query_live: assert property (
      stb_query |=> resp_valid
                    && resp_data[BIT_REQUEST] == $past(master_summary))
      else $error("query byte bit 6 is not the master summary");

   a_query_bits: assert property (
      stb_query |=> (resp_data & ~REQ_BIT_MASK)
                    == ($past(summary) & ~REQ_BIT_MASK))
      else $error("query byte summary bits wrong");

   // the flag is registered, so it shows one edge after the rise
   a_rise_sets: assert property (
      $rose(master_summary) |=> request_service_flag && service_request)
      else $error("enabled rise did not raise a request");

   a_rise_flag: assert property (
      any_rise |=> request_service_flag)
      else $error("lane rise did not set the request flag");

   a_flag_quiet: assert property (
      !request_service_flag && !any_rise |=> !request_service_flag)
      else $error("request flag set with no enabled rise");

   a_flag_holds: assert property (
      request_service_flag && !serial_poll |=> request_service_flag)
      else $error("request flag dropped without a poll");

   a_poll_clears: assert property (
      serial_poll && !any_rise |=> !request_service_flag && !service_request)
      else $error("poll did not clear the request flag");

   a_repeat_req: assert property (
      serial_poll && !any_rise ##1 any_rise |=> request_service_flag)
      else $error("second rise after poll did not request");

   a_poll_keeps_master: assert property (
      serial_poll && master_summary && $stable(summary)
      |=> status_summary_byte[BIT_REQUEST])
      else $error("poll cleared the master summary");

   a_mask_store: assert property (
      mask_wr ##1 (mask_rd && !stb_query && !mask_wr)
      |=> resp_valid && resp_data == $past(mask_wdata, 2))
      else $error("mask read back differs from write");

   a_mask_query: assert property (
      mask_rd && !stb_query
      |=> resp_valid && resp_data == $past(request_enable_mask))
      else $error("mask query answer differs from the mask");

   a_resp_pulse: assert property (
      !stb_query && !mask_rd |=> !resp_valid)
      else $error("answer pulse without a query");

   a_mask_holds: assert property (
      !mask_wr |=> $stable(request_enable_mask))
      else $error("mask changed without a write");

   a_mask_zero_wr: assert property (
      mask_wr && mask_wdata == BYTE_ZERO |=> request_enable_mask == MASK_RESET)
      else $error("zero write did not clear the mask");

   a_mask_reset: assert property (
      @(posedge ref_clk) disable iff (1'b0)
      rst |=> request_enable_mask == MASK_RESET)
      else $error("mask not zero after power-up");

   a_mask_kept: assert property (
      (clear_status || status_preset) && !mask_wr
      |=> $stable(request_enable_mask))
      else $error("clear or preset changed the mask");

   a_poll_answer: assert property (
      serial_poll |=> poll_valid ##1 !poll_valid || $past(serial_poll))
      else $error("poll answer missing or stretched");

   a_poll_pulse: assert property (
      !serial_poll |=> !poll_valid)
      else $error("poll answer without a poll");

   a_err_example: assert property (
      request_enable_mask == ONLY_ERR_QUEUE && error_queue_nonempty && !mask_wr
      |=> status_summary_byte[BIT_ERR_QUEUE]
          && status_summary_byte[BIT_REQUEST])
      else $error("enabled error did not set bits 2 and 6");

   a_bit1_zero: assert property (
      !status_summary_byte[BIT_UNUSED] && !poll_byte[BIT_UNUSED]
      && !rise[BIT_UNUSED] && !rise[BIT_REQUEST])
      else $error("unused bit or mask bit made a request");

   a_line_flag: assert property (
      service_request == request_service_flag)
      else $error("request line differs from request flag");

   c_request: cover property (
      !service_request ##1 service_request);

   c_poll_with_flag: cover property (
      request_service_flag && serial_poll ##1 !request_service_flag);

   c_second_request: cover property (
      serial_poll ##[1:8] $rose(service_request));

   c_mask_write: cover property (
      mask_wr ##1 mask_rd);

   c_query_master: cover property (
      stb_query ##1 resp_valid && resp_data[BIT_REQUEST]);

endmodule

`default_nettype wire

/* testbench/poll_controller.sv */
// Purpose: bus controller model that serial-polls on a service request.
// Assumes: serial_poll changes 1 ns after ref_clk rises; last_byte and poll_count 2 ns.
// Notes:   slow waits four idle cycles first; the byte is taken late
//          so the bench never races it.
`timescale 1ns/10ps
`default_nettype none
module poll_controller (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       service_request,
   input  wire logic       poll_valid,
   input  wire logic [7:0] poll_byte,
   input  wire logic       auto_en,
   input  wire logic       slow,
   output var  logic       serial_poll,
   output var  logic [7:0] last_byte,
   output var  int         poll_count
);
   initial begin
      serial_poll = 1'b0;
      last_byte = 8'h00;
      poll_count = 0;
      forever begin
         @(posedge ref_clk);
         if (!rst && auto_en && service_request) begin
            repeat (slow ? 4 : 0) @(posedge ref_clk);
            #1 serial_poll = 1'b1;
            @(posedge ref_clk);
            #1 serial_poll = 1'b0;
            #1 if (poll_valid) last_byte = poll_byte;
            poll_count++;
         end
      end
   end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Purpose: self-checking bench for the status byte and request logic.
// Assumes: inputs change 1 ns after ref_clk rises.
// Notes:   a local model of the byte gives the expected byte in the bit walk and random traffic.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import srq_pkg::*;
   logic       ref_clk, rst, mask_wr, mask_rd, stb_query, clear_status;
   logic       status_preset, service_request, request_service_flag;
   logic       resp_valid, poll_valid, serial_poll, auto_en, slow, q, wr;
   logic [7:0] src_v, mask_wdata, status_summary_byte, request_enable_mask;
   logic [7:0] resp_data, poll_byte, last_byte, m, e;
   int         poll_count, errors, total_checks, n0;

   service_request_status_byte uut (
      .ref_clk(ref_clk), .rst(rst),
      .measurement_summary(src_v[0]), .error_queue_nonempty(src_v[2]),
      .questionable_summary(src_v[3]), .output_message_ready(src_v[4]),
      .standard_event_summary(src_v[5]), .operation_summary(src_v[7]),
      .mask_wr(mask_wr), .mask_wdata(mask_wdata), .mask_rd(mask_rd),
      .stb_query(stb_query), .serial_poll(serial_poll),
      .clear_status(clear_status), .status_preset(status_preset),
      .status_summary_byte(status_summary_byte),
      .request_enable_mask(request_enable_mask),
      .service_request(service_request),
      .request_service_flag(request_service_flag),
      .resp_valid(resp_valid), .resp_data(resp_data),
      .poll_valid(poll_valid), .poll_byte(poll_byte));

   poll_controller ctl (
      .ref_clk(ref_clk), .rst(rst), .service_request(service_request),
      .poll_valid(poll_valid), .poll_byte(poll_byte), .auto_en(auto_en),
      .slow(slow), .serial_poll(serial_poll), .last_byte(last_byte),
      .poll_count(poll_count));

   // live byte: unused bits forced low, bit6 is the master summary
   function automatic logic [7:0] sb(logic [7:0] s, logic [7:0] k);
      logic [7:0] t;
      t = s & REQ_CAPABLE;
      return t | {1'b0, |(t & k), 6'h00};
   endfunction

   task automatic cyc();
      @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(logic [8:0] got, logic [8:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic poll(logic s);
      n0 = poll_count;
      slow = s;
      auto_en = 1'b1;
      for (int i = 0; i < 20 && poll_count == n0; i++) cyc();
      auto_en = 1'b0;
      if (poll_count == n0) begin
         errors++;
         print_verdict();
      end
   endtask

   task automatic wr_mask(logic [7:0] w);
      mask_wr = 1'b1;
      mask_wdata = w;
      cyc();
      mask_wr = 1'b0;
      m = w;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   initial begin
      void'($urandom(32'hcd75aae4));
      {rst, mask_wr, mask_rd, stb_query, clear_status} = 5'h10;
      {status_preset, auto_en, slow, src_v, mask_wdata, m} = '0;
      errors = 0;
      total_checks = 0;
      repeat (16) cyc();
      rst = 1'b0;
      cyc();
      chk({service_request, status_summary_byte}, 9'h000);
      chk(request_enable_mask, MASK_RESET);
      for (int i = 0; i < 6; i++) begin
         wr_mask(i == 0 ? 8'hff : i == 5 ? 8'h00 : 8'($urandom));
         {mask_rd, clear_status, status_preset} = 3'b111;
         cyc();
         {mask_rd, clear_status, status_preset} = 3'b000;
         chk({resp_valid, resp_data}, {1'b1, m});
         chk(request_enable_mask, m);
      end
      wr_mask(8'h42);
      src_v = 8'hff;
      cyc();
      cyc();
      chk({service_request, status_summary_byte}, 9'h0bd);
      src_v = 8'h00;
      for (int b = 0; b < 8; b++) begin
         if (REQ_CAPABLE[b]) begin
            wr_mask(8'h01 << b);
            src_v[b] = 1'b1;
            cyc();
            e = sb(src_v, m);
            chk(status_summary_byte[b], 1'b1);
            chk({service_request, status_summary_byte}, {1'b1, e});
            poll(b[0]);
            chk(last_byte, e);
            chk({request_service_flag, status_summary_byte}, {1'b0, e});
            src_v[b] = 1'b0;
            cyc();
            chk({service_request, status_summary_byte}, 9'h000);
            src_v[b] = 1'b1;
            cyc();
            chk(request_service_flag, 1'b1);
            poll(1'b0);
            src_v[b] = 1'b0;
         end
      end
      wr_mask(ONLY_ERR_QUEUE);
      src_v[2] = 1'b1;
      stb_query = 1'b1;
      cyc();
      stb_query = 1'b0;
      chk({resp_valid, resp_data}, 9'h144);
      chk(service_request, 1'b1);
      // random traffic, with the controller polling now and then
      for (int i = 0; i < 300; i++) begin
         src_v = 8'($urandom);
         q = $urandom_range(3) == 0;
         wr = $urandom_range(7) == 0;
         {stb_query, mask_wr, mask_wdata} = {q, wr, 8'($urandom)};
         {auto_en, slow} = 2'($urandom);
         e = sb(src_v, m);
         cyc();
         chk(status_summary_byte, e);
         if (q) chk({resp_valid, resp_data}, {1'b1, e});
         if (wr) m = mask_wdata;
      end
      {stb_query, mask_wr, auto_en} = 3'b000;
      cyc();
      print_verdict();
   end
endmodule
`default_nettype wire
